// ### pkg/dplb_pkg.sv
// Constants and types for the dual programmable logic cells.
// Assumes an AXI4-Lite master with 32-bit data and 12-bit byte addresses.
//
// Notes on behaviour
// (RL1) The first cell's selector picks off, AND, OR, XOR, latch, or passes A, B or C for codes 000 to 111.
// (RL2) The second cell's selector uses the same eight codes as the first cell.
// (RL3) Bits 3, 4 and 5 of the first configuration invert inputs A, B and C before the cell.
// (RL4) Bit 6 of the first configuration inverts the first cell's output.
// (RL5) Bits 3, 4 and 5 of the second configuration invert inputs A, B and C before the cell.
// (RL6) Bit 6 of the second configuration inverts the second cell's output.
// (RL7) Bit 7 of the second configuration feeds the first cell's output into the second cell's A input.
// (RL8) While chaining is on, the row-zero pin is released and no longer carries the first cell's output.
// (RL9) Writing 1 to force bit 1 sets the first latch, 1 to bit 0 clears it, and 0 leaves it alone.
// (RL10) Writing 1 to force bit 3 sets the second latch, 1 to bit 2 clears it, and 0 leaves it alone.
// (RL11) AND, OR and XOR combine the three inputs after input inversion and before output inversion.
// (RL12) In off mode the cell output is low before output inversion.
package dplb_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CELL1_CFG = 8'h44;
	localparam logic [7:0] IDX_CELL2_CFG = 8'h45;
	localparam logic [7:0] IDX_FF_FORCE = 8'h46;
	localparam int ADDR_W = 12;
	localparam logic [7:0] RST_CELL1_CFG = 8'h00;
	localparam logic [7:0] RST_CELL2_CFG = 8'h00;
	localparam logic [7:0] RST_FF_FORCE = 8'h00;
	localparam logic [7:0] MASK_CELL1_CFG = 8'h7f;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int POS_SEL = 0;
	localparam int POS_INV_A = 3;
	localparam int POS_INV_B = 4;
	localparam int POS_INV_C = 5;
	localparam int POS_OUT_INV = 6;
	localparam int POS_CHAIN = 7;
	localparam int POS_FIRST_CELL_LATCH_FORCE_CLEAR = 0;
	localparam int POS_FIRST_CELL_LATCH_FORCE_SET = 1;
	localparam int POS_SECOND_CELL_LATCH_FORCE_CLEAR = 2;
	localparam int POS_SECOND_CELL_LATCH_FORCE_SET = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		FN_OFF = 3'h0,
		FN_AND = 3'h1,
		FN_OR = 3'h2,
		FN_XOR = 3'h3,
		FN_LATCH = 3'h4,
		FN_PASS_A = 3'h5,
		FN_PASS_B = 3'h6,
		FN_PASS_C = 3'h7
	} dplb_func_t;

	typedef enum logic [1:0] {REG_C1, REG_C2, REG_FF, REG_NONE} dplb_reg_t;

	typedef struct packed {
		logic [7:0] cfg1;
		logic [7:0] cfg2;
		logic [7:0] force_bits;
		logic latch1;
		logic latch2;
		logic clk1_prev;
		logic clk2_prev;
		logic out1;
		logic out2;
		logic rz_oe;
		logic aw_held;
		logic w_held;
		logic [11:0] awaddr;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
	} dplb_state_t;

endpackage : dplb_pkg

// ### logic/dplb_top.sv
// Two configurable logic cells with an AXI4-Lite register slave.
// Assumes cell inputs are synchronous to aclk and one outstanding access per channel.
`timescale 1ns/1ps
module dplb_top import dplb_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic first_cell_input_a,
	input wire logic first_cell_input_b,
	input wire logic first_cell_input_c,
	input wire logic second_cell_input_a,
	input wire logic second_cell_input_b,
	input wire logic second_cell_input_c,
	output logic first_cell_output,
	output logic second_cell_output,
	output logic row_zero_pin_out,
	output logic row_zero_pin_oe
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic dplb_reg_t reg_decode(input logic [11:0] addr);
		dplb_reg_t r;
		r = REG_NONE;
		if (addr[11:2] == {2'h0, IDX_CELL1_CFG}) begin
			r = REG_C1;
		end else if (addr[11:2] == {2'h0, IDX_CELL2_CFG}) begin
			r = REG_C2;
		end else if (addr[11:2] == {2'h0, IDX_FF_FORCE}) begin
			r = REG_FF;
		end
		return r;
	endfunction : reg_decode

	// Output of one cell: inputs already inverted, latch as held before this cycle's update
	function automatic logic cell_eval(input logic [7:0] cfg, input logic a, input logic b,
		input logic c, input logic latch);
		logic y;
		y = 1'b0;
		case (dplb_func_t'(cfg[POS_SEL +: 3]))  // RL1 RL2
			FN_OFF: y = 1'b0;  // RL12
			FN_AND: y = a & b & c;  // RL11
			FN_OR: y = a | b | c;  // RL11
			FN_XOR: y = a ^ b ^ c;  // RL11
			FN_LATCH: y = latch;
			FN_PASS_A: y = a;
			FN_PASS_B: y = b;
			FN_PASS_C: y = c;
			default: y = 1'b0;
		endcase
		return y ^ cfg[POS_OUT_INV];  // RL4 RL6
	endfunction : cell_eval

	dplb_state_t state_reg;
	dplb_state_t state_next;
	logic wr_fire;
	logic ff_wr;
	logic a1, b1, c1, a2, b2, c2;

	assign wr_fire = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
	assign ff_wr = wr_fire && state_reg.wstrb0 && reg_decode(state_reg.awaddr) == REG_FF;

	// ----------------------------------------------------------------
	// Input conditioning
	// ----------------------------------------------------------------
	assign a1 = first_cell_input_a ^ state_reg.cfg1[POS_INV_A];  // RL3
	assign b1 = first_cell_input_b ^ state_reg.cfg1[POS_INV_B];  // RL3
	assign c1 = first_cell_input_c ^ state_reg.cfg1[POS_INV_C];  // RL3
	assign a2 = (state_reg.cfg2[POS_CHAIN] ? state_reg.out1 : second_cell_input_a)
		^ state_reg.cfg2[POS_INV_A];  // RL7 RL5
	assign b2 = second_cell_input_b ^ state_reg.cfg2[POS_INV_B];  // RL5
	assign c2 = second_cell_input_c ^ state_reg.cfg2[POS_INV_C];  // RL5

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		// Write channel capture, either order
		if (awvalid && state_reg.awready) begin
			state_next.aw_held = 1'b1;
			state_next.awaddr = awaddr;
		end
		if (wvalid && state_reg.wready) begin
			state_next.w_held = 1'b1;
			state_next.wdata = wdata[7:0];
			state_next.wstrb0 = wstrb[0];
		end
		if (state_reg.bvalid && bready) begin
			state_next.bvalid = 1'b0;
		end
		if (wr_fire) begin
			state_next.aw_held = 1'b0;
			state_next.w_held = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = RESP_OKAY;
			case (reg_decode(state_reg.awaddr))
				REG_C1: begin
					if (state_reg.wstrb0) begin
						state_next.cfg1 = state_reg.wdata & MASK_CELL1_CFG;
					end
				end
				REG_C2: begin
					if (state_reg.wstrb0) begin
						state_next.cfg2 = state_reg.wdata;
					end
				end
				REG_FF: begin
					if (state_reg.wstrb0) begin
						state_next.force_bits = state_reg.wdata;
					end
				end
				default: state_next.bresp = RESP_SLVERR;
			endcase
		end
		state_next.awready = !state_next.aw_held && !state_next.bvalid;
		state_next.wready = !state_next.w_held && !state_next.bvalid;

		// Read channel
		if (state_reg.rvalid && rready) begin
			state_next.rvalid = 1'b0;
		end
		if (arvalid && state_reg.arready) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = RESP_OKAY;
			case (reg_decode(araddr))
				REG_C1: state_next.rdata = state_reg.cfg1;
				REG_C2: state_next.rdata = state_reg.cfg2;
				REG_FF: state_next.rdata = state_reg.force_bits;
				default: begin
					state_next.rdata = 8'h00;
					state_next.rresp = RESP_SLVERR;
				end
			endcase
		end
		state_next.arready = !state_next.rvalid;

		// Latches capture A on a rising edge of B
		state_next.clk1_prev = b1;
		state_next.clk2_prev = b2;
		if (b1 && !state_reg.clk1_prev) begin
			state_next.latch1 = a1;
		end
		if (b2 && !state_reg.clk2_prev) begin
			state_next.latch2 = a2;
		end
		// Software force overrides the edge; clear wins over set
		if (ff_wr && state_reg.wdata[POS_FIRST_CELL_LATCH_FORCE_SET]) begin
			state_next.latch1 = 1'b1;  // RL9
		end
		if (ff_wr && state_reg.wdata[POS_FIRST_CELL_LATCH_FORCE_CLEAR]) begin
			state_next.latch1 = 1'b0;  // RL9
		end
		if (ff_wr && state_reg.wdata[POS_SECOND_CELL_LATCH_FORCE_SET]) begin
			state_next.latch2 = 1'b1;  // RL10
		end
		if (ff_wr && state_reg.wdata[POS_SECOND_CELL_LATCH_FORCE_CLEAR]) begin
			state_next.latch2 = 1'b0;  // RL10
		end

		state_next.out1 = cell_eval(state_reg.cfg1, a1, b1, c1, state_reg.latch1);  // RL1 RL4
		state_next.out2 = cell_eval(state_reg.cfg2, a2, b2, c2, state_reg.latch2);  // RL2 RL6
		state_next.rz_oe = (state_reg.cfg1[POS_SEL +: 3] != FN_OFF) && !state_reg.cfg2[POS_CHAIN];  // RL8
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
			state_reg.cfg1 <= RST_CELL1_CFG;
			state_reg.cfg2 <= RST_CELL2_CFG;
			state_reg.force_bits <= RST_FF_FORCE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign awready = state_reg.awready;
	assign wready = state_reg.wready;
	assign bvalid = state_reg.bvalid;
	assign bresp = state_reg.bresp;
	assign arready = state_reg.arready;
	assign rvalid = state_reg.rvalid;
	assign rresp = state_reg.rresp;
	assign rdata = {24'h000000, state_reg.rdata};
	assign first_cell_output = state_reg.out1;
	assign second_cell_output = state_reg.out2;
	assign row_zero_pin_out = state_reg.out1;
	assign row_zero_pin_oe = state_reg.rz_oe;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_and1;
		state_reg.cfg1 == 8'h01 && first_cell_input_a && first_cell_input_b && first_cell_input_c
			|=> first_cell_output;
	endproperty
	a_and1: assert property (p_and1) else $error("AND on first cell wrong");  // RL1

	property p_pass_a2;
		state_reg.cfg2 == 8'h05 |=> second_cell_output == $past(second_cell_input_a);
	endproperty
	a_pass_a2: assert property (p_pass_a2) else $error("Pass A on second cell wrong");  // RL2

	property p_inv_b1;
		state_reg.cfg1 == 8'h16 |=> first_cell_output == !$past(first_cell_input_b);
	endproperty
	a_inv_b1: assert property (p_inv_b1) else $error("Input B inversion on first cell wrong");  // RL3

	property p_outinv1;
		state_reg.cfg1 == 8'h47 |=> first_cell_output == !$past(first_cell_input_c);
	endproperty
	a_outinv1: assert property (p_outinv1) else $error("Output inversion on first cell wrong");  // RL4

	property p_inv_c2;
		state_reg.cfg2 == 8'h27 |=> second_cell_output == !$past(second_cell_input_c);
	endproperty
	a_inv_c2: assert property (p_inv_c2) else $error("Input C inversion on second cell wrong");  // RL5

	property p_outinv2;
		state_reg.cfg2 == 8'h40 |=> second_cell_output;
	endproperty
	a_outinv2: assert property (p_outinv2) else $error("Output inversion on second cell wrong");  // RL6

	property p_chain;
		state_reg.cfg2 == 8'h85 |=> second_cell_output == $past(first_cell_output);
	endproperty
	a_chain: assert property (p_chain) else $error("Chained A input wrong");  // RL7

	property p_rz_free;
		state_reg.cfg2[POS_CHAIN] |=> !row_zero_pin_oe;
	endproperty
	a_rz_free: assert property (p_rz_free) else $error("Row zero pin driven while chained");  // RL8

	property p_first_cell_latch_force_set;
		ff_wr && state_reg.wdata[1:0] == 2'h2 |=> state_reg.latch1;
	endproperty
	a_first_cell_latch_force_set: assert property (p_first_cell_latch_force_set) else $error("First latch not set");  // RL9

	property p_second_cell_latch_force_clear;
		ff_wr && state_reg.wdata[2] |=> !state_reg.latch2;
	endproperty
	a_second_cell_latch_force_clear: assert property (p_second_cell_latch_force_clear) else $error("Second latch not cleared");  // RL10

	property p_xor1;
		state_reg.cfg1 == 8'h03 |=> first_cell_output ==
			($past(first_cell_input_a) ^ $past(first_cell_input_b) ^ $past(first_cell_input_c));
	endproperty
	a_xor1: assert property (p_xor1) else $error("XOR on first cell wrong");  // RL11

	property p_off1;
		state_reg.cfg1 == 8'h00 |=> !first_cell_output;
	endproperty
	a_off1: assert property (p_off1) else $error("Off mode output not low");  // RL12

	property p_or2;
		state_reg.cfg2 == 8'h02 |=> second_cell_output ==
			($past(second_cell_input_a) | $past(second_cell_input_b) | $past(second_cell_input_c));
	endproperty
	a_or2: assert property (p_or2) else $error("OR on second cell wrong");  // RL11

	property p_inv_a2;
		state_reg.cfg2 == 8'h0d |=> second_cell_output == !$past(second_cell_input_a);
	endproperty
	a_inv_a2: assert property (p_inv_a2) else $error("Input A inversion on second cell wrong");  // RL5

	property p_latch1;
		state_reg.cfg1 == 8'h04 |=> first_cell_output == $past(state_reg.latch1);
	endproperty
	a_latch1: assert property (p_latch1) else $error("Latch mode on first cell wrong");  // RL1

	property p_first_cell_latch_force_clear;
		ff_wr && state_reg.wdata[0] |=> !state_reg.latch1;
	endproperty
	a_first_cell_latch_force_clear: assert property (p_first_cell_latch_force_clear) else $error("First latch not cleared");  // RL9

	property p_second_cell_latch_force_set;
		ff_wr && state_reg.wdata[3:2] == 2'h2 |=> state_reg.latch2;
	endproperty
	a_second_cell_latch_force_set: assert property (p_second_cell_latch_force_set) else $error("Second latch not set");  // RL10

	property p_rz_drive;
		state_reg.cfg1[2:0] != 3'h0 && !state_reg.cfg2[POS_CHAIN] |=> row_zero_pin_oe;
	endproperty
	a_rz_drive: assert property (p_rz_drive) else $error("Row zero pin not driven");  // RL8

endmodule : dplb_top

// ### sim/dplb_pins.sv
// Model of the external pins that feed the two logic cells.
// Assumes the bench hands it the wanted pin levels; it drives them from the clock edge.
`timescale 1ns/1ps
module dplb_pins (
	input wire logic aclk,
	input wire logic [5:0] level,
	output logic a1,
	output logic b1,
	output logic c1,
	output logic a2,
	output logic b2,
	output logic c2
);
	// ----------------------------------------------------------------
	// Pin drivers, synchronous to the device clock
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		{c2, b2, a2, c1, b1, a1} <= level;
	end
endmodule : dplb_pins

// ### sim/tb_dplb_top.sv
// Self-checking bench for the dual logic cells and their register slave.
// Assumes dplb_pkg, dplb_top and the pin model dplb_pins are compiled first.
`timescale 1ns/1ps
module tb_dplb_top import dplb_pkg::*; ;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
	logic rready = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [3:0] wstrb = 4'hf;
	logic [5:0] lev = 6'h00;
	logic awready, wready, bvalid, arready, rvalid, o1, o2, rz, rzoe, a1, b1, c1, a2, b2, c2;
	logic [1:0] bresp, rresp;
	int n_fail = 0, n_tests = 0;

	dplb_pins u_dplb_pins (.aclk(aclk), .level(lev), .a1(a1), .b1(b1), .c1(c1), .a2(a2), .b2(b2), .c2(c2));
	dplb_top u_dplb_top (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.first_cell_input_a(a1), .first_cell_input_b(b1), .first_cell_input_c(c1),
		.second_cell_input_a(a2), .second_cell_input_b(b2), .second_cell_input_c(c2),
		.first_cell_output(o1), .second_cell_output(o2), .row_zero_pin_out(rz), .row_zero_pin_oe(rzoe));

	initial begin
		forever #50 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic give_verdict;
		if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		@(posedge aclk);
		awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (k == 50) begin n_fail++; give_verdict(); end
		chk(bresp, er, "write response");
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int k;
		@(posedge aclk);
		arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (k == 50) begin n_fail++; give_verdict(); end
		chk(rdata, ed, "read data");
		chk(rresp, er, "read response");
	endtask : rd

	// Expected cell output, latch mode excluded
	function automatic logic fexp(input logic [7:0] cfg, input logic a, input logic b, input logic c);
		logic x, y, z, o;
		x = a ^ cfg[3]; y = b ^ cfg[4]; z = c ^ cfg[5];
		case (cfg[2:0])
			3'h1: o = x & y & z;
			3'h2: o = x | y | z;
			3'h3: o = x ^ y ^ z;
			3'h5: o = x;
			3'h6: o = y;
			3'h7: o = z;
			default: o = 1'b0;
		endcase
		return o ^ cfg[6];
	endfunction : fexp

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		rd(12'h110, 32'h0, RESP_OKAY);
		rd(12'h114, 32'h0, RESP_OKAY);
		rd(12'h118, 32'h0, RESP_OKAY);
		wr(12'h110, 32'hffff_ffff, RESP_OKAY);
		rd(12'h110, 32'h7f, RESP_OKAY);
		wr(12'h114, 32'ha5, RESP_OKAY);
		rd(12'h114, 32'ha5, RESP_OKAY);
		wstrb <= 4'he;
		wr(12'h114, 32'h00, RESP_OKAY);
		wstrb <= 4'hf;
		rd(12'h114, 32'ha5, RESP_OKAY);
		wr(12'h200, 32'h1, RESP_SLVERR);
		rd(12'h200, 32'h0, RESP_SLVERR);
	endtask : t_regs

	task automatic t_cells;
		logic [7:0] cfg;
		for (int s = 0; s < 8; s++) begin
			if (s == 4) continue;
			for (int v = 0; v < 16; v++) begin
				cfg = {1'b0, v[3:0], s[2:0]};
				wr(12'h110, {24'h0, cfg}, RESP_OKAY);
				wr(12'h114, {24'h0, cfg}, RESP_OKAY);
				for (int p = 0; p < 8; p++) begin
					lev <= {~p[2:0], p[2:0]};
					repeat (3) @(posedge aclk);
					chk(o1, fexp(cfg, p[0], p[1], p[2]), "first cell");
					chk(o2, fexp(cfg, ~p[0], ~p[1], ~p[2]), "second cell");
					chk(rz, fexp(cfg, p[0], p[1], p[2]), "row zero level");
					chk(rzoe, s != 0, "row zero enable");
				end
			end
		end
	endtask : t_cells

	task automatic t_chain;
		wr(12'h110, 32'h05, RESP_OKAY);
		wr(12'h114, 32'h85, RESP_OKAY);
		for (int i = 0; i < 2; i++) begin
			lev <= {2'b00, ~i[0], 2'b00, i[0]};
			repeat (4) @(posedge aclk);
			chk(o2, i[0], "chained input");
			chk(rzoe, 1'b0, "row zero released");
		end
	endtask : t_chain

	task automatic t_latch;
		logic [7:0] f[5] = '{8'h02, 8'h00, 8'h08, 8'h01, 8'h04};
		logic [1:0] e[5] = '{2'b01, 2'b01, 2'b11, 2'b10, 2'b00};
		lev <= 6'h00;
		wr(12'h110, 32'h04, RESP_OKAY);
		wr(12'h114, 32'h04, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			wr(12'h118, {24'h0, f[i]}, RESP_OKAY);
			repeat (3) @(posedge aclk);
			chk({o2, o1}, e[i], "latch force");
		end
		rd(12'h118, 32'h04, RESP_OKAY);
		lev <= 6'h09;
		repeat (2) @(posedge aclk);
		lev <= 6'h1b;
		repeat (4) @(posedge aclk);
		chk({o2, o1}, 2'b11, "latch capture");
	endtask : t_latch

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_cells();
		t_chain();
		t_latch();
		give_verdict();
	end

	initial begin
		repeat (100000) @(posedge aclk);
		n_fail++;
		give_verdict();
	end
endmodule : tb_dplb_top
